// ---- hw/irq_pkg.sv ----
`default_nettype none
package irq_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // word indices on the register bus
  localparam logic [3:0] OFS_INTCTL   = 4'h0;
  localparam logic [3:0] OFS_PEN1     = 4'h1;
  localparam logic [3:0] OFS_PEN2     = 4'h2;
  localparam logic [3:0] OFS_SRC_STAT = 4'h3;
  localparam logic [3:0] OFS_SH_BASE  = 4'h8;

  // ----------------------------------------------------------------
  // interrupt_control bit positions
  // ----------------------------------------------------------------
  localparam int GEN_B   = 7;
  localparam int PGATE_B = 6;
  localparam int T0IE_B = 5;
  localparam int EXIE_B = 4;
  localparam int PCIE_B = 3;
  localparam int T0IF_B = 2;
  localparam int EXF_B  = 1;
  localparam int PCIF_B = 0;

  // peripheral_irq_enable_2 implemented bits 7, 3, 0
  localparam logic [7:0] PEN2_MASK  = 8'h89;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // context save
  // ----------------------------------------------------------------
  localparam int SH_COUNT  = 8;
  localparam int SH_IDX_W  = 3;
  localparam int SH_STATUS = 1;
  // timeout and powerdown status bits (4, 3) are never copied in the entry save
  localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;

  localparam int PC_W = 15;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ENTRY  = 3'b010,
    ST_RETURN = 3'b100
  } seq_state_t;

endpackage
`default_nettype wire

// ---- hw/ctx_shadow.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctx_shadow #(
  parameter int COUNT = irq_pkg::SH_COUNT
) (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic                               save,
  input  wire logic [COUNT*irq_pkg::BYTE_W-1:0]   live_ctx,
  input  wire logic                               wr_en,
  input  wire logic [irq_pkg::SH_IDX_W-1:0]       wr_index,
  input  wire logic [irq_pkg::BYTE_W-1:0]         wr_data,
  output logic      [COUNT*irq_pkg::BYTE_W-1:0]   shadow_ctx
);

  // ----------------------------------------------------------------
  // shadow storage, one byte per saved register
  // ----------------------------------------------------------------
  logic [irq_pkg::BYTE_W-1:0] shadow_reg  [COUNT];
  logic [irq_pkg::BYTE_W-1:0] shadow_next [COUNT];

  genvar i;
  generate
    for (i = 0; i < COUNT; i++)
    begin : g_entry
      // entry save wins over a software write in the same cycle
      always_comb
      begin
        shadow_next[i] = shadow_reg[i];
        if (save)
        begin
          if (i == irq_pkg::SH_STATUS)
            shadow_next[i] = live_ctx[i*irq_pkg::BYTE_W +: irq_pkg::BYTE_W]
                             & irq_pkg::STATUS_SAVE_MASK;
          else
            shadow_next[i] = live_ctx[i*irq_pkg::BYTE_W +: irq_pkg::BYTE_W];
        end
        else if (wr_en && int'(wr_index) == i)
          shadow_next[i] = wr_data;
      end

      always_ff @(posedge clock)
      begin
        if (rst)
          shadow_reg[i] <= irq_pkg::REG_RESET;
        else
          shadow_reg[i] <= shadow_next[i];
      end

      assign shadow_ctx[i*irq_pkg::BYTE_W +: irq_pkg::BYTE_W] = shadow_reg[i];
    end
  endgenerate

endmodule
`default_nettype wire

// ---- hw/irq_enable_context_save.sv ----
// What this block does
// RULE1: on entry push the return program counter onto the return stack
// RULE2: on entry copy accumulator, status less timeout/powerdown, bank, file
// RULE3: on return restore every shadowed register from its shadow copy
// RULE4: shadow copies readable and writable; written value is restored
// RULE5: flags set on their event regardless of any enable bit
// RULE6: software should clear flags before setting matching enables
// RULE7: global enable bit 7 allows enabled interrupts, blocks all when 0
// RULE8: peripheral gate bit 6 must be 1 for peripheral sources
// RULE9: timer0 enable bit 5, flag bit 2, flag set on overflow
// RULE10: external pin enable bit 4, flag bit 1, set on pin event
// RULE11: pin-change enable bit 3, flag bit 0 while any change recorded
// RULE12: pin-change summary read-only, clears when all port flags clear
// RULE13: first enable register maps eight peripheral enables bits 7..0
// RULE14: second enable register: osc fail 7, collision 3, capture2 0
// RULE15: unused second enable bits read zero and ignore writes
// RULE16: all implemented enable and control bits reset to zero
// RULE17: on entry flush prefetch, clear global enable, push, save, vector
// RULE18: return pops address, restores context, sets global enable
// RULE19: external pin edge chosen by edge select: 1 rising, 0 falling
// RULE20: request is global enable and any enabled, gated source pair
`timescale 1ns/10ps
`default_nettype none
module irq_enable_context_save (
  input  wire logic                          clock,
  input  wire logic                          rst,
  // avalon-mm slave
  input  wire logic [irq_pkg::ADDR_W-1:0]    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [irq_pkg::DATA_W-1:0]    writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [irq_pkg::DATA_W-1:0]    readdata,
  output logic                               waitrequest,
  // event sources
  input  wire logic                          timer0_overflow,
  input  wire logic                          ext_pin,
  input  wire logic                          ext_edge_select,
  input  wire logic [7:0]                    port_pin_change_flags,
  input  wire logic [7:0]                    periph1_flags,
  input  wire logic [7:0]                    periph2_flags,
  // core side
  output logic                               irq_request,
  input  wire logic                          irq_accept,
  input  wire logic                          return_from_irq,
  input  wire logic [irq_pkg::PC_W-1:0]      core_pc,
  input  wire logic [63:0]                   live_ctx,
  output logic                               flush_prefetch,
  output logic                               stack_push,
  output logic      [irq_pkg::PC_W-1:0]      stack_push_data,
  output logic                               stack_pop,
  output logic                               vector_load,
  output logic      [irq_pkg::PC_W-1:0]      vector_addr,
  output logic                               restore_valid,
  output logic      [63:0]                   restore_ctx
);

  // ----------------------------------------------------------------
  // bus slave: one wait state, then the request is taken
  // ----------------------------------------------------------------
  logic                         bus_ack_reg;
  logic                         bus_ack_next;
  logic [irq_pkg::DATA_W-1:0]   rdata_reg;
  logic [irq_pkg::DATA_W-1:0]   rdata_next;
  logic                         bus_req;
  logic                         wr_take;
  logic                         lane0;
  logic [7:0]                   wbyte;
  logic [7:0]                   intctl_view;
  logic [63:0]                  shadow_ctx;
  logic                         sh_hit;
  logic [7:0]                   pen1_reg;
  logic [7:0]                   pen2_reg;
  irq_pkg::seq_state_t          state_reg;

  assign bus_req     = read | write;
  assign waitrequest = bus_req & ~bus_ack_reg;
  assign wr_take     = write & bus_ack_reg;
  assign lane0       = byteenable[0];
  assign wbyte       = writedata[7:0];
  assign readdata    = rdata_reg;
  assign sh_hit      = address[3] == irq_pkg::OFS_SH_BASE[3];

  // read data is latched in the wait cycle so it stands at the take edge
  always_comb
  begin
    bus_ack_next = bus_req & ~bus_ack_reg;
    rdata_next   = rdata_reg;
    if (read && !bus_ack_reg)
    begin
      rdata_next = '0;
      if (sh_hit)
        rdata_next[7:0] = shadow_ctx[address[2:0]*8 +: 8];
      else
        case (address)
          irq_pkg::OFS_INTCTL:   rdata_next[7:0] = intctl_view;
          irq_pkg::OFS_PEN1:     rdata_next[7:0] = pen1_reg;
          irq_pkg::OFS_PEN2:     rdata_next[7:0] = pen2_reg;
          irq_pkg::OFS_SRC_STAT:
            rdata_next[7:0] = periph1_flags;
          default:               rdata_next     = '0;
        endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bus_ack_reg <= 1'b0;
      rdata_reg   <= '0;
    end
    else
    begin
      bus_ack_reg <= bus_ack_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // control and enable registers
  // ----------------------------------------------------------------
  logic [7:0] intctl_reg;
  logic [7:0] intctl_next;
  logic [7:0] pen1_next;
  logic [7:0] pen2_next;
  logic       ext_prev_reg;
  logic       ext_edge;
  logic       pc_summary;
  logic       enter_now;
  logic       ret_now;
  logic       wr_ctl;

  assign wr_ctl = wr_take & lane0;
  assign enter_now = state_reg == irq_pkg::ST_ENTRY;
  assign ret_now   = state_reg == irq_pkg::ST_RETURN;

  // RULE19 edge select
  // the pin is sampled each clock; only the chosen edge counts
  assign ext_edge = ext_edge_select ? (ext_pin & ~ext_prev_reg)
                                    : (~ext_pin & ext_prev_reg);

  // RULE11 change summary
  // RULE12 clears with port flags
  // summary follows the port flags, so it drops only once all are clear
  assign pc_summary = |port_pin_change_flags;

  always_comb
  begin
    intctl_view = intctl_reg;
    intctl_view[irq_pkg::PCIF_B] = pc_summary;
  end

  // software write first, then hardware set and clear override it
  always_comb
  begin
    intctl_next = intctl_reg;
    pen1_next   = pen1_reg;
    pen2_next   = pen2_reg;
    if (wr_ctl && address == irq_pkg::OFS_INTCTL)
      intctl_next[7:1] = wbyte[7:1];
    // RULE13 enable map
    if (wr_ctl && address == irq_pkg::OFS_PEN1)
      pen1_next = wbyte;
    // RULE14 second map
    // RULE15 unused read zero
    if (wr_ctl && address == irq_pkg::OFS_PEN2)
      pen2_next = wbyte & irq_pkg::PEN2_MASK;
    // RULE5 flags always set
    // RULE9 timer0 flag
    // set wins over a same-cycle software clear
    if (timer0_overflow)
      intctl_next[irq_pkg::T0IF_B] = 1'b1;
    // RULE10 external flag
    if (ext_edge)
      intctl_next[irq_pkg::EXF_B] = 1'b1;
    // RULE17 clear global enable
    if (enter_now)
      intctl_next[irq_pkg::GEN_B] = 1'b0;
    // RULE18 set global enable
    if (ret_now)
      intctl_next[irq_pkg::GEN_B] = 1'b1;
    intctl_next[irq_pkg::PCIF_B] = 1'b0;
  end

  // RULE16 reset to zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      intctl_reg   <= irq_pkg::REG_RESET;
      pen1_reg     <= irq_pkg::REG_RESET;
      pen2_reg     <= irq_pkg::REG_RESET;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      intctl_reg   <= intctl_next;
      pen1_reg     <= pen1_next;
      pen2_reg     <= pen2_next;
      ext_prev_reg <= ext_pin;
    end
  end

  // ----------------------------------------------------------------
  // request to the core
  // ----------------------------------------------------------------
  logic core_any;
  logic periph_any;

  assign core_any =
      (intctl_reg[irq_pkg::T0IE_B] & intctl_reg[irq_pkg::T0IF_B])
    | (intctl_reg[irq_pkg::EXIE_B] & intctl_reg[irq_pkg::EXF_B])
    | (intctl_reg[irq_pkg::PCIE_B] & pc_summary);

  // RULE8 peripheral gate
  assign periph_any = intctl_reg[irq_pkg::PGATE_B]
                    & (|(pen1_reg & periph1_flags)
                     | |(pen2_reg & periph2_flags));

  // RULE7 global enable
  // RULE20 request combine
  // held off while an entry or return is in flight
  assign irq_request = intctl_reg[irq_pkg::GEN_B]
                     & (core_any | periph_any)
                     & (state_reg == irq_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // entry and return sequencer
  // ----------------------------------------------------------------
  irq_pkg::seq_state_t        state_next;
  logic [irq_pkg::PC_W-1:0]   push_pc_reg;
  logic [irq_pkg::PC_W-1:0]   push_pc_next;
  logic [63:0]                restore_reg;
  logic [63:0]                restore_next;

  always_comb
  begin
    state_next   = state_reg;
    push_pc_next = push_pc_reg;
    restore_next = restore_reg;
    case (state_reg)
      irq_pkg::ST_IDLE:
      begin
        if (irq_request && irq_accept)
        begin
          state_next   = irq_pkg::ST_ENTRY;
          push_pc_next = core_pc;
        end
        else if (return_from_irq)
        begin
          state_next   = irq_pkg::ST_RETURN;
          restore_next = shadow_ctx;
        end
      end
      irq_pkg::ST_ENTRY:  state_next = irq_pkg::ST_IDLE;
      irq_pkg::ST_RETURN: state_next = irq_pkg::ST_IDLE;
      default:            state_next = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg   <= irq_pkg::ST_IDLE;
      push_pc_reg <= '0;
      restore_reg <= '0;
    end
    else
    begin
      state_reg   <= state_next;
      push_pc_reg <= push_pc_next;
      restore_reg <= restore_next;
    end
  end

  // RULE1 push return pc
  // RULE17 flush and vector
  assign flush_prefetch  = enter_now;
  assign stack_push      = enter_now;
  assign stack_push_data = push_pc_reg;
  assign vector_load     = enter_now;
  assign vector_addr     = irq_pkg::IRQ_VECTOR;

  // RULE3 restore context
  // RULE18 pop and restore
  // live edits made in the routine are overwritten by these copies
  assign stack_pop     = ret_now;
  assign restore_valid = ret_now;
  assign restore_ctx   = restore_reg;

  // ----------------------------------------------------------------
  // shadow bank
  // ----------------------------------------------------------------
  // RULE2 save on entry
  // RULE4 shadow access
  ctx_shadow #(
    .COUNT (irq_pkg::SH_COUNT)
  ) u_shadow (
    .clock      (clock),
    .rst        (rst),
    .save       (state_reg == irq_pkg::ST_IDLE && irq_request
                 && irq_accept),
    .live_ctx   (live_ctx),
    .wr_en      (wr_ctl && sh_hit),
    .wr_index   (address[2:0]),
    .wr_data    (wbyte),
    .shadow_ctx (shadow_ctx)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  global_block_a: assert property ( // RULE7
    @(posedge clock) disable iff (rst)
    !intctl_reg[irq_pkg::GEN_B] |-> !irq_request)
    else $error("request raised with global enable low");

  periph_gate_a: assert property ( // RULE8
    @(posedge clock) disable iff (rst)
    (!intctl_reg[irq_pkg::PGATE_B] && !core_any) |-> !irq_request)
    else $error("peripheral request passed a closed gate");

  timer_flag_a: assert property ( // RULE9
    @(posedge clock) disable iff (rst)
    timer0_overflow |=> intctl_reg[irq_pkg::T0IF_B])
    else $error("timer0 flag not set after overflow");

  ext_edge_a: assert property ( // RULE19
    @(posedge clock) disable iff (rst)
    (ext_edge_select && ext_pin && !$past(ext_pin))
      |=> intctl_reg[irq_pkg::EXF_B])
    else $error("rising edge did not set external flag");

  summary_flag_a: assert property ( // RULE12
    @(posedge clock) disable iff (rst)
    intctl_view[irq_pkg::PCIF_B] == (port_pin_change_flags != 8'h00))
    else $error("pin-change summary out of step");

  peripheral_irq_enable_2_unused_a: assert property ( // RULE15
    @(posedge clock) disable iff (rst)
    (pen2_reg & ~irq_pkg::PEN2_MASK) == 8'h00)
    else $error("unused second enable bit set");

  entry_seq_a: assert property ( // RULE17
    @(posedge clock) disable iff (rst)
    (irq_request && irq_accept) |=> stack_push && vector_load
      && stack_push_data == $past(core_pc)
      ##1 !intctl_reg[irq_pkg::GEN_B])
    else $error("entry sequence wrong");

  return_seq_a: assert property ( // RULE18
    @(posedge clock) disable iff (rst)
    (state_reg == irq_pkg::ST_IDLE && !irq_accept && return_from_irq)
      |=> stack_pop && restore_valid && restore_ctx == $past(shadow_ctx)
      ##1 intctl_reg[irq_pkg::GEN_B])
    else $error("return sequence wrong");

  status_mask_a: assert property ( // RULE2
    @(posedge clock) disable iff (rst)
    (irq_request && irq_accept)
      |=> shadow_ctx[15:8] == ($past(live_ctx[15:8])
                               & irq_pkg::STATUS_SAVE_MASK))
    else $error("status shadow not masked copy");

endmodule
`default_nettype wire

// ---- bench/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// stands for the core sequencer: takes a request when allowed by the
// bench, keeps the pushed return address, fires the return on command
module core_model (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     accept_en,
  input  wire logic                     ret_cmd,
  input  wire logic                     irq_request,
  input  wire logic                     stack_push,
  input  wire logic [irq_pkg::PC_W-1:0] stack_push_data,
  output logic                          irq_accept,
  output logic                          return_from_irq,
  output logic      [irq_pkg::PC_W-1:0] pushed_pc
);
  // accept lags the request a cycle, like a core finishing its fetch
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_accept      <= 1'b0;
      return_from_irq <= 1'b0;
      pushed_pc       <= '0;
    end
    else
    begin
      irq_accept      <= accept_en & irq_request;
      return_from_irq <= ret_cmd;
      if (stack_push)
        pushed_pc <= stack_push_data;
    end
  end
endmodule
`default_nettype wire

// ---- bench/irq_enable_context_save_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module irq_enable_context_save_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock, rst, read, write, ext_pin, ext_edge_select;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata;
  logic        waitrequest, timer0_overflow, irq_request, irq_accept;
  logic [7:0]  port_pin_change_flags, periph1_flags, periph2_flags;
  logic        return_from_irq, flush_prefetch, stack_push, stack_pop;
  logic [14:0] core_pc, stack_push_data, vector_addr, pushed_pc;
  logic [63:0] live_ctx, restore_ctx;
  logic        vector_load, restore_valid, accept_en, ret_cmd;
  int          error_cnt, checks;
  // status byte all ones so the masked save is visible
  localparam logic [63:0] LIVE = 64'h112233445566ff77;

  irq_enable_context_save irq_enable_context_save_i (.clock(clock),
    .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer0_overflow(timer0_overflow),
    .ext_pin(ext_pin), .ext_edge_select(ext_edge_select),
    .port_pin_change_flags(port_pin_change_flags),
    .periph1_flags(periph1_flags), .periph2_flags(periph2_flags),
    .irq_request(irq_request), .irq_accept(irq_accept),
    .return_from_irq(return_from_irq), .core_pc(core_pc),
    .live_ctx(live_ctx), .flush_prefetch(flush_prefetch),
    .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_pop(stack_pop), .vector_load(vector_load),
    .vector_addr(vector_addr), .restore_valid(restore_valid),
    .restore_ctx(restore_ctx));

  core_model core_model_i (.clock(clock), .rst(rst), .accept_en(accept_en),
    .ret_cmd(ret_cmd), .irq_request(irq_request), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .irq_accept(irq_accept),
    .return_from_irq(return_from_irq), .pushed_pc(pushed_pc));

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    complete_run();
  end

  task automatic complete_run();
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus and stimulus helpers
  // ----------------------------------------------------------------
  // request stands until the edge that closes a cycle with waitrequest
  // low; read data is taken at that edge, then the request is dropped
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clock);
    address   <= a;
    writedata <= {24'h000000, d};
    read      <= ~wr;
    write     <= wr;
    do
      @(negedge clock);
    while (waitrequest !== 1'b0);
    @(posedge clock);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, {24'h000000, e}, q)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regs_test();
    rd("intctl", 4'h0, 8'h00);
    rd("pen1", 4'h1, 8'h00);
    rd("pen2", 4'h2, 8'h00);
    wr(4'h1, 8'hff);
    rd("pen1 all", 4'h1, 8'hff);
    wr(4'h2, 8'hff);
    rd("pen2 mask", 4'h2, 8'h89);
    byteenable <= 4'h0;
    wr(4'h1, 8'h00);
    byteenable <= 4'h1;
    rd("pen1 lane", 4'h1, 8'hff);
    wr(4'h5, 8'hff);
    rd("unmapped", 4'h5, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
  endtask

  task automatic flags_test();
    @(posedge clock);
    timer0_overflow <= 1'b1;
    @(posedge clock);
    timer0_overflow <= 1'b0;
    ext_pin         <= 1'b1;
    rd("t0 ext flag", 4'h0, 8'h06);
    `CHK("no req genable0", 1'b0, irq_request)
    wr(4'h0, 8'h00);
    ext_edge_select       <= 1'b0;
    port_pin_change_flags <= 8'h10;
    ext_pin               <= 1'b0;
    rd("fall pc", 4'h0, 8'h03);
    wr(4'h0, 8'h00);
    rd("pc ro", 4'h0, 8'h01);
    port_pin_change_flags <= 8'h00;
    rd("pc clr", 4'h0, 8'h00);
  endtask

  task automatic entry_test();
    core_pc   <= 15'h1234;
    live_ctx  <= LIVE;
    // flags cleared above before the enable is set
    // clear first
    wr(4'h0, 8'ha0);
    @(posedge clock);
    timer0_overflow <= 1'b1;
    accept_en       <= 1'b1;
    @(posedge clock);
    timer0_overflow <= 1'b0;
    do
      @(negedge clock);
    while (stack_push !== 1'b1);
    `CHK("flush", 1'b1, flush_prefetch)
    `CHK("vector", 1'b1, vector_load)
    `CHK("vec addr", 15'h0004, vector_addr)
    @(negedge clock);
    `CHK("push pc", 15'h1234, pushed_pc)
    @(posedge clock);
    accept_en <= 1'b0;
    rd("genable off", 4'h0, 8'h24);
    rd("sh status", 4'h9, 8'he7);
    rd("sh bank", 4'ha, 8'h66);
    rd("sh pcl", 4'hf, 8'h11);
    wr(4'h8, 8'h5a);
    rd("sh acc wr", 4'h8, 8'h5a);
    live_ctx <= 64'hffffffffffffffff;
    wr(4'h0, 8'h20);
    @(posedge clock);
    ret_cmd <= 1'b1;
    @(posedge clock);
    ret_cmd <= 1'b0;
    do
      @(negedge clock);
    while (restore_valid !== 1'b1);
    `CHK("pop", 1'b1, stack_pop)
    `CHK("restore", 64'h112233445566e75a, restore_ctx)
    rd("genable back", 4'h0, 8'ha0);
  endtask

  task automatic periph_test();
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h01);
    periph1_flags <= 8'h01;
    rd("p1 flags", 4'h3, 8'h01);
    `CHK("gate off", 1'b0, irq_request)
    wr(4'h0, 8'hc0);
    @(negedge clock);
    `CHK("gate on", 1'b1, irq_request)
    wr(4'h0, 8'h40);
    @(negedge clock);
    `CHK("genable blocks", 1'b0, irq_request)
    periph1_flags <= 8'h00;
    // second enable register path through the gate
    wr(4'h2, 8'h08);
    periph2_flags <= 8'h08;
    wr(4'h0, 8'hc0);
    @(negedge clock);
    `CHK("pen2 path", 1'b1, irq_request)
    // pin-change enable needs no peripheral gate
    periph2_flags         <= 8'h00;
    port_pin_change_flags <= 8'h01;
    wr(4'h0, 8'h88);
    @(negedge clock);
    `CHK("pc enable", 1'b1, irq_request)
    wr(4'h0, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    checks    = 0;
    {read, write, timer0_overflow, ext_pin, accept_en, ret_cmd} = '0;
    rst = 1'b1;
    ext_edge_select = 1'b1;
    address = 4'h0;
    writedata = '0;
    byteenable = 4'h1;
    {port_pin_change_flags, periph1_flags, periph2_flags} = '0;
    core_pc  = '0;
    live_ctx = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    regs_test();
    flags_test();
    entry_test();
    periph_test();
    complete_run();
  end
endmodule
`default_nettype wire
